// [srh_pkg.sv]
// Shared constants, types and carriers of the status reporting hierarchy.
// Summary of operation
// - Five parallel 16-bit parts, same bit per source.
// - Bit 15 of every part reads zero.
// - Condition part mirrors hardware or child summary.
// - Condition part read-only; reads change nothing.
// - Rising condition sets event if rise filter set.
// - Falling condition sets event if fall filter set.
// - Transition filters writable; reads leave them unchanged.
// - Event part latches, read-only, cleared by read.
// - Summary is OR of event AND enable.
// - Enable part writable; reads leave it unchanged.
// - Summary feeds designated parent condition bit.
// - Status byte bit 6 is master summary.
// - Mask bit 6 ignored for summary and request.
// - Enabled status byte bit rising raises request.
// - Status byte query and poll return current value.
// - Service request mask is stored and read back.
// - Status byte bit 1 is device summary.
// - Bit 2 is error queue busy; entries request.
// - Status byte bit 3 is questionable summary.
// - Status byte bit 4 is message waiting.
// - Status byte bit 5 is standard event summary.
// - Status byte bit 7 is operation summary.
package srh_pkg;

	// ==========================================================================
	// Sizes, reset values and bit positions
	localparam int          SRH_W        = 16;
	localparam int          SRH_GROUPS   = 5;
	localparam logic [15:0] SRH_LIVE     = 16'h7fff;
	localparam logic [15:0] SRH_RISE_RST = 16'h7fff;
	localparam logic [15:0] SRH_FALL_RST = 16'h0000;
	localparam logic [15:0] SRH_ENAB_RST = 16'h0000;
	localparam logic [7:0]  SRH_SRE_RST  = 8'h00;
	localparam logic [7:0]  SRH_MSS_OFF  = 8'hbe;
	localparam int          STB_DEV      = 1;
	localparam int          STB_ERRQ     = 2;
	localparam int          STB_QUES     = 3;
	localparam int          STB_MAV      = 4;
	localparam int          STB_ESB      = 5;
	localparam int          STB_MSS      = 6;
	localparam int          STB_OPER     = 7;
	localparam int          QUES_POW_BIT = 3;
	localparam int          QUES_CAL_BIT = 8;

	// ==========================================================================
	// Command targets; the first five are the status groups in index order
	typedef enum logic [2:0] {
		TGT_DEV, TGT_QUES, TGT_QPOW, TGT_QCAL, TGT_OPER, TGT_STB, TGT_SRE
	} srh_target_t;

	typedef enum logic [2:0] {
		PART_COND, PART_RISE, PART_FALL, PART_EVENT, PART_ENABLE
	} srh_part_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		srh_target_t target;
		srh_part_t   part;
		logic [15:0] data;
	} srh_cmd_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} srh_rsp_t;

	typedef struct packed {
		logic [15:0] cond;
		logic [15:0] rise;
		logic [15:0] fall;
		logic [15:0] latched;
		logic [15:0] enable;
	} srh_group_t;

endpackage : srh_pkg

// [srh_status_group.sv]
// One status group: condition, two transition filters, event latch, enable.
`timescale 1ns/1ps
module srh_status_group import srh_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [14:0] cond_in,
	input  wire logic        wr_en,
	input  wire srh_part_t   wr_part,
	input  wire logic [15:0] wr_data,
	input  wire logic        clr_event,
	output srh_group_t       regs,
	output logic             sum
);

	logic [15:0] cond;
	logic [15:0] rise;
	logic [15:0] fall;
	logic [15:0] latched;
	logic [15:0] enable;
	logic [15:0] next_cond;
	logic [15:0] hit;

	assign next_cond = {1'b0, cond_in};
	assign hit = ((next_cond & ~cond & rise) | (~next_cond & cond & fall)) & SRH_LIVE;

	always_ff @(posedge clk) begin
		if (rst) begin
			cond <= '0;
		end else begin
			cond <= next_cond;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rise   <= SRH_RISE_RST;
			fall   <= SRH_FALL_RST;
			enable <= SRH_ENAB_RST;
		end else if (wr_en) begin
			if (wr_part == PART_RISE) rise <= wr_data & SRH_LIVE;
			if (wr_part == PART_FALL) fall <= wr_data & SRH_LIVE;
			if (wr_part == PART_ENABLE) enable <= wr_data & SRH_LIVE;
		end
	end

	// A transition in the clearing cycle survives the clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			latched <= '0;
		end else begin
			latched <= (clr_event ? 16'h0000 : latched) | hit;
		end
	end

	assign sum  = |(latched & enable);
	assign regs = '{cond: cond, rise: rise, fall: fall, latched: latched, enable: enable};

endmodule : srh_status_group

// [srh_service_request.sv]
// Status byte register, master summary and service request generation.
`timescale 1ns/1ps
module srh_service_request import srh_pkg::*; (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] src,
	input  wire logic [7:0] service_request_mask,
	input  wire logic       err_entry,
	output logic [7:0]      status_byte,
	output logic            service_request
);

	logic [7:0] enabled;
	logic [7:0] prev_enabled;
	logic [7:0] next_stb;

	assign enabled = src & service_request_mask & SRH_MSS_OFF;

	always_comb begin
		next_stb          = src;
		next_stb[0]       = 1'b0;
		next_stb[STB_MSS] = |enabled;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			status_byte     <= '0;
			prev_enabled    <= '0;
			service_request <= 1'b0;
		end else begin
			status_byte     <= next_stb;
			prev_enabled    <= enabled;
			service_request <= (|(enabled & ~prev_enabled)) | (err_entry & service_request_mask[STB_ERRQ]);
		end
	end

endmodule : srh_service_request

// [srh_status_hierarchy.sv]
// Top of the status reporting hierarchy: groups, status byte and command port.
`timescale 1ns/1ps
module srh_status_hierarchy import srh_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire srh_cmd_t    cmd,
	output srh_rsp_t         rsp,
	input  wire logic [14:0] dev_cond,
	input  wire logic [14:0] ques_cond,
	input  wire logic [14:0] qpow_cond,
	input  wire logic [14:0] qcal_cond,
	input  wire logic [14:0] oper_cond,
	input  wire logic        err_queue_busy,
	input  wire logic        err_entry,
	input  wire logic        message_waiting,
	input  wire logic        standard_event_summary,
	output logic [7:0]       status_byte,
	output logic             service_request,
	output logic             master_summary
);

	// ==========================================================================
	// Command decoding

	srh_group_t              grp [SRH_GROUPS];
	logic [SRH_GROUPS-1:0]   sums;
	logic [14:0]             cond_vec [SRH_GROUPS];
	logic [SRH_GROUPS-1:0]   grp_wr;
	logic [SRH_GROUPS-1:0]   grp_clr;
	logic [7:0]              service_request_mask;
	logic [7:0]              stb_src;
	logic [7:0]              stb_q;
	logic                    srq_q;
	srh_group_t              sel_grp;
	logic                    is_query;

	function automatic logic is_group(input srh_target_t t);
		return t < TGT_STB;
	endfunction : is_group

	function automatic logic [15:0] part_value(input srh_group_t g, input srh_part_t p);
		logic [15:0] v;
		v = 16'h0000;
		unique case (p)
			PART_COND:   v = g.cond;
			PART_RISE:   v = g.rise;
			PART_FALL:   v = g.fall;
			PART_EVENT:  v = g.latched;
			PART_ENABLE: v = g.enable;
			default:     v = 16'h0000;
		endcase
		return v & SRH_LIVE;
	endfunction : part_value

	assign is_query = cmd.valid && !cmd.write;

	always_comb begin
		for (int g = 0; g < SRH_GROUPS; g++) begin
			grp_wr[g]  = cmd.valid && cmd.write && cmd.target == srh_target_t'(3'(g));
			grp_clr[g] = is_query && cmd.part == PART_EVENT
				&& cmd.target == srh_target_t'(3'(g));
		end
	end

	always_comb begin
		sel_grp = '0;
		if (is_group(cmd.target)) begin
			sel_grp = grp[3'(cmd.target)];
		end
	end

	// ==========================================================================
	// Condition inputs of each group

	// Child summaries replace the hardware bits they are routed into.
	always_comb begin
		cond_vec[TGT_DEV]  = dev_cond;
		cond_vec[TGT_QUES] = ques_cond;
		cond_vec[TGT_QUES][QUES_POW_BIT] = sums[TGT_QPOW];
		cond_vec[TGT_QUES][QUES_CAL_BIT] = sums[TGT_QCAL];
		cond_vec[TGT_QPOW] = qpow_cond;
		cond_vec[TGT_QCAL] = qcal_cond;
		cond_vec[TGT_OPER] = oper_cond;
	end

	// ==========================================================================
	// Status groups

	for (genvar g = 0; g < SRH_GROUPS; g++) begin : gen_group
		// Each group keeps its five parts bit-aligned per source.
		srh_status_group u_group (
			.clk       (clk),
			.rst       (rst),
			.cond_in   (cond_vec[g]),
			.wr_en     (grp_wr[g]),
			.wr_part   (cmd.part),
			.wr_data   (cmd.data),
			.clr_event (grp_clr[g]),
			.regs      (grp[g]),
			.sum       (sums[g])
		);
	end

	// ==========================================================================
	// Status byte and service request mask

	always_comb begin
		stb_src           = 8'h00;
		stb_src[STB_DEV]  = sums[TGT_DEV];
		stb_src[STB_ERRQ] = err_queue_busy;
		stb_src[STB_QUES] = sums[TGT_QUES];
		stb_src[STB_MAV]  = message_waiting;
		stb_src[STB_ESB]  = standard_event_summary;
		stb_src[STB_OPER] = sums[TGT_OPER];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			service_request_mask <= SRH_SRE_RST;
		end else if (cmd.valid && cmd.write && cmd.target == TGT_SRE) begin
			service_request_mask <= cmd.data[7:0];
		end
	end

	srh_service_request u_request (
		.clk             (clk),
		.rst             (rst),
		.src             (stb_src),
		.service_request_mask             (service_request_mask),
		.err_entry       (err_entry),
		.status_byte     (stb_q),
		.service_request (srq_q)
	);

	assign status_byte     = stb_q;
	assign service_request = srq_q;
	assign master_summary  = stb_q[STB_MSS];

	// ==========================================================================
	// Query answers

	// Every query is answered on the next edge; writes give no answer.
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp <= '0;
		end else begin
			rsp.valid <= is_query;
			if (!is_query) begin
				rsp.data <= 16'h0000;
			end else if (is_group(cmd.target)) begin
				rsp.data <= part_value(sel_grp, cmd.part);
			end else if (cmd.target == TGT_STB) begin
				rsp.data <= {8'h00, stb_q};
			end else begin
				rsp.data <= {8'h00, service_request_mask};
			end
		end
	end

	// ==========================================================================
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic bit15_any;
	logic dev_hit0;

	always_comb begin
		bit15_any = 1'b0;
		for (int g = 0; g < SRH_GROUPS; g++) begin
			bit15_any = bit15_any | grp[g].cond[15] | grp[g].rise[15]
				| grp[g].fall[15] | grp[g].latched[15] | grp[g].enable[15];
		end
	end

	assign dev_hit0 = (dev_cond[0] && !grp[TGT_DEV].cond[0] && grp[TGT_DEV].rise[0])
		|| (!dev_cond[0] && grp[TGT_DEV].cond[0] && grp[TGT_DEV].fall[0]);

	a_bit15_zero: assert property (!bit15_any)
		else $error("bit 15 of a group part is set");

	a_cond_mirror: assert property (
		1 |=> grp[TGT_OPER].cond == {1'b0, $past(oper_cond)})
		else $error("condition part does not follow its inputs");

	a_cond_no_write: assert property (
		cmd.valid && cmd.write && cmd.target == TGT_DEV && cmd.part == PART_COND
		&& dev_cond == grp[TGT_DEV].cond[14:0]
		|=> $stable(grp[TGT_DEV].cond))
		else $error("write changed the condition part");

	a_rise_event: assert property (
		dev_cond[0] && !grp[TGT_DEV].cond[0] && grp[TGT_DEV].rise[0]
		|=> grp[TGT_DEV].latched[0])
		else $error("filtered rising edge not latched");

	a_fall_event: assert property (
		!dev_cond[0] && grp[TGT_DEV].cond[0] && grp[TGT_DEV].fall[0]
		|=> grp[TGT_DEV].latched[0])
		else $error("filtered falling edge not latched");

	a_no_stray_event: assert property (
		!grp[TGT_DEV].latched[0] && !dev_hit0 |=> !grp[TGT_DEV].latched[0])
		else $error("event bit set without filtered transition");

	a_filter_write: assert property (
		cmd.valid && cmd.write && cmd.target == TGT_QUES && cmd.part == PART_FALL
		|=> grp[TGT_QUES].fall == ($past(cmd.data) & SRH_LIVE))
		else $error("fall filter did not store written value");

	a_filter_read: assert property (
		is_query && cmd.target == TGT_QUES && cmd.part == PART_RISE
		&& !(cmd.valid && cmd.write)
		|=> $stable(grp[TGT_QUES].rise) ##0 rsp.data == grp[TGT_QUES].rise)
		else $error("rise filter read failed or altered it");

	a_event_clear: assert property (
		grp_clr[TGT_DEV] && !dev_hit0 |=> !grp[TGT_DEV].latched[0])
		else $error("event read did not clear the bit");

	a_event_read_data: assert property (
		grp_clr[TGT_OPER]
		|=> rsp.valid && rsp.data == $past(grp[TGT_OPER].latched))
		else $error("event query returned wrong value");

	a_clear_race: assert property (
		grp_clr[TGT_DEV] && dev_hit0 |=> grp[TGT_DEV].latched[0])
		else $error("event lost during clearing read");

	a_sum_parent: assert property (
		sums[TGT_QPOW] |=> grp[TGT_QUES].cond[QUES_POW_BIT]
		##1 (stb_q[STB_QUES] == $past(sums[TGT_QUES])))
		else $error("child summary did not reach parent");

	a_sum_or: assert property (
		sums[TGT_OPER] == |(grp[TGT_OPER].latched & grp[TGT_OPER].enable))
		else $error("summary bit mismatch");

	a_enable_keep: assert property (
		!(cmd.valid && cmd.write) |=> $stable(grp[TGT_DEV].enable))
		else $error("enable part changed without a write");

	a_master_sum: assert property (
		1 |=> stb_q[STB_MSS] == |($past(stb_src) & $past(service_request_mask) & SRH_MSS_OFF))
		else $error("master summary mismatch");

	a_srq_rise: assert property (
		$rose(stb_src[STB_OPER]) && service_request_mask[STB_OPER] && $stable(service_request_mask)
		|=> service_request)
		else $error("no service request on enabled rising bit");

	a_srq_cause: assert property (
		!err_entry && $stable(stb_src & service_request_mask) |=> !service_request)
		else $error("service request without a cause");

	a_errq_entry: assert property (
		err_entry && service_request_mask[STB_ERRQ] |=> service_request)
		else $error("error entry did not request service");

	a_stb_query: assert property (
		is_query && cmd.target == TGT_STB
		|=> rsp.valid && rsp.data == {8'h00, $past(stb_q)})
		else $error("status byte query wrong");

	a_sre_store: assert property (
		cmd.valid && cmd.write && cmd.target == TGT_SRE
		|=> service_request_mask == $past(cmd.data[7:0]))
		else $error("service request mask not stored");

	a_stb_map: assert property (
		1 |=> stb_q[STB_DEV] == $past(sums[TGT_DEV])
		&& stb_q[STB_MAV] == $past(message_waiting)
		&& stb_q[STB_ESB] == $past(standard_event_summary))
		else $error("status byte bit mapping wrong");

	a_stb_bit0: assert property (!stb_q[0])
		else $error("status byte bit 0 set");

	c_event_read: cover property (grp_clr[TGT_DEV] && grp[TGT_DEV].latched[0]);
	c_clear_race: cover property (grp_clr[TGT_DEV] && dev_hit0);
	c_chain_srq: cover property (sums[TGT_QCAL] ##[1:4] service_request);
	c_err_srq: cover property (err_entry && service_request_mask[STB_ERRQ]);

endmodule : srh_status_hierarchy

// [srh_host_model.sv]
// Host model: presents one command per cycle on the command port.
`timescale 1ns/1ps
module srh_host_model import srh_pkg::*; (
	input  wire logic clk,
	output srh_cmd_t  cmd
);

	initial cmd = '0;

	// ==========================================================================
	// Request
	// The command is held for one full cycle and taken at the next rising edge.
	task automatic issue(input srh_cmd_t c);
		cmd <= c;
		@(posedge clk);
	endtask : issue

endmodule : srh_host_model

// [testbench.sv]
// Self-checking bench of the status reporting hierarchy against a lockstep model.
`timescale 1ns/1ps
module testbench import srh_pkg::*;;

	logic        clk;
	logic        rst;
	srh_cmd_t    cmd;
	srh_rsp_t    rsp;
	logic [14:0] hw [5];
	logic        eqb;
	logic        ee;
	logic        mw;
	logic        ses;
	logic [7:0]  status_byte;
	logic        service_request;
	logic        master_summary;
	logic [31:0] seed;
	logic        live;
	int          err_count;
	int          cmp_count;
	int          m [5][5];
	int          m_sre;
	int          m_stb;
	int          m_rd;
	int          m_pmsk;
	logic        m_rv;
	logic        m_srq;

	initial clk = 1'b0;
	always #2 clk = ~clk;

	srh_host_model host_u (.clk(clk), .cmd(cmd));

	srh_status_hierarchy dut_u (
		.clk                    (clk),
		.rst                    (rst),
		.cmd                    (cmd),
		.rsp                    (rsp),
		.dev_cond               (hw[0]),
		.ques_cond              (hw[1]),
		.qpow_cond              (hw[2]),
		.qcal_cond              (hw[3]),
		.oper_cond              (hw[4]),
		.err_queue_busy         (eqb),
		.err_entry              (ee),
		.message_waiting        (mw),
		.standard_event_summary (ses),
		.status_byte            (status_byte),
		.service_request        (service_request),
		.master_summary         (master_summary)
	);

	// ==========================================================================
	// Reference model, updated at the same edges as the design
	always @(posedge clk) begin
		int s [5];
		int nc;
		int hit;
		int src;
		int msk;
		int t;
		int p;
		t = int'(cmd.target);
		p = int'(cmd.part);
		m_rv = 1'b0;
		m_rd = 0;
		m_srq = 1'b0;
		if (rst) begin
			for (int g = 0; g < 5; g++) begin
				m[g] = '{0, int'(SRH_RISE_RST), int'(SRH_FALL_RST), 0, int'(SRH_ENAB_RST)};
			end
			m_sre = int'(SRH_SRE_RST);
			m_stb = 0;
			m_pmsk = 0;
		end else begin
			for (int g = 0; g < 5; g++) begin
				s[g] = ((m[g][3] & m[g][4]) != 0);
			end
			if (cmd.valid && !cmd.write) begin
				m_rv = 1'b1;
				m_rd = (t == 5) ? m_stb : (t == 6) ? m_sre : m[t][p];
			end
			for (int g = 0; g < 5; g++) begin
				nc = hw[g];
				if (g == 1) begin
					nc = (nc & 'h7ef7) | (s[2] << 3) | (s[3] << 8);
				end
				hit = ((~m[g][0] & nc & m[g][1]) | (m[g][0] & ~nc & m[g][2])) & 'h7fff;
				if (cmd.valid && !cmd.write && t == g && cmd.part == PART_EVENT) begin
					m[g][3] = hit;
				end else begin
					m[g][3] = m[g][3] | hit;
				end
				m[g][0] = nc;
			end
			src = (s[4] << 7) | (ses << 5) | (mw << 4) | (s[1] << 3) | (eqb << 2) | (s[0] << 1);
			msk = src & m_sre & 'hbe;
			m_srq = ((msk & ~m_pmsk) != 0) || (ee && m_sre[2]);
			m_pmsk = msk;
			m_stb = src | ((msk != 0) << 6);
			if (cmd.valid && cmd.write) begin
				if (t == 6) begin
					m_sre = cmd.data & 'hff;
				end else if (t < 5 && p != 0 && p != 3) begin
					m[t][p] = cmd.data & 'h7fff;
				end
			end
		end
	end

	// ==========================================================================
	// Comparison and verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	always @(negedge clk) begin
		if (live) begin
			check({8'h00, status_byte}, 16'(m_stb));
			check({15'h0000, master_summary}, 16'((m_stb >> 6) & 1));
			check({15'h0000, service_request}, {15'h0000, m_srq});
			check({15'h0000, rsp.valid}, {15'h0000, m_rv});
			check(rsp.data, 16'(m_rd));
		end
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h000000c5 : 32'h00000000);
	endfunction : lfsr_next

	// ==========================================================================
	// Stimulus
	// Sparse condition flips keep transitions frequent while events still latch.
	initial begin
		rst = 1'b1;
		live = 1'b0;
		eqb = 1'b0;
		ee = 1'b0;
		mw = 1'b0;
		ses = 1'b0;
		seed = 32'h0aece552;
		err_count = 0;
		cmp_count = 0;
		for (int g = 0; g < 5; g++) begin
			hw[g] = 15'h0000;
		end
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		live <= 1'b1;
		for (int i = 0; i < 3000; i++) begin
			seed = lfsr_next(seed);
			for (int g = 0; g < 5; g++) begin
				if (seed[g]) begin
					hw[g] <= hw[g] ^ (15'(seed >> 8) & 15'(seed >> 17));
				end
			end
			if (seed[5]) begin
				eqb <= seed[6];
				mw <= seed[13];
				ses <= seed[14];
			end
			ee <= seed[7] & seed[9] & seed[11];
			host_u.issue('{valid: seed[20] | seed[21], write: seed[22],
				target: srh_target_t'(seed[26:24] % 3'h7), part: srh_part_t'(seed[29:27] % 3'h5),
				data: 16'(seed >> 12)});
		end
		stop_test();
	end

	initial begin
		#20000;
		err_count++;
		stop_test();
	end

endmodule : testbench
